/* hdl/tpc_top.sv */
//
// Contract
// [RL1] Tune request clears match latch, pad in.
// [RL2] RF plus low reflection sets match latch.
// [RL3] Reflection lost after match: delayed pad reinsert.
// [RL4] Fault lamp follows failure latch.
// [RL5] Ready lamp when tuning completed.
// [RL6] Tuning lamp follows tuning latch.
// [RL7] RF-present indication only after a delay.
// [RL8] Tuning without RF forces match latch clear.
// [RL9] Tune pulse holds debounced low-reflection cleared.
// [RL10] Tune request drives both home lines low.
// [RL11] Match found restarts reinsertion delay.
// [RL12] Tuning latch set clears failure latch.
// [RL13] Inductor at maximum forces pad in.
// [RL14] Debounce drops instantly, rebuilds slowly.
// [RL15] Timeout ends tuning and sets failure.
// [RL16] High reflection when idle: fault, pad in.
// [RL17] RF and low reflection end tuning.
// [RL18] Clocked counters, synchronised inputs.
// [RL19] Clearing beats setting on match latch.
//
`timescale 1ns/1ps
`default_nettype none
`include "tpc_cfg.svh"

module tpc_top #(
    parameter logic [31:0] RF_DELAY_CYC  = 32'(`TPC_RF_DELAY_CYC),
    parameter logic [31:0] BELOW_DEB_CYC = 32'(`TPC_BELOW_DEB_CYC),
    parameter logic [31:0] REINSERT_CYC  = 32'(`TPC_REINSERT_CYC),
    parameter logic [31:0] TIMEOUT_CYC   = 32'(`TPC_TIMEOUT_CYC)
) (
    input  wire logic              clk_sys_i,          // 40 MHz clock.
    input  wire logic              reset_n_i,          // Async reset, low.
    input  wire tpc_pkg::tpc_pins_t pins_i,            // Raw pin inputs.
    input  wire logic [7:0]        addr_i,             // Register address.
    input  wire logic [31:0]       wdata_i,            // Write data.
    input  wire logic              we_i,               // Write strobe.
    input  wire logic              re_i,               // Read strobe.
    output logic      [31:0]       rdata_o,            // Read data.
    output logic                   irq_o,              // Level interrupt.
    output var tpc_pkg::tpc_lamps_t lamps_o,           // Lamp drivers.
    output logic                   pad_energize_o,     // Pad relay on.
    output logic                   rf_present_o,       // Delayed RF flag.
    output logic                   match_found_o,      // Debounced low refl.
    output logic                   capacitor_home_req_n_o, // Home, low.
    output logic                   inductor_home_req_n_o   // Home, low.
);

    import tpc_pkg::*;

    // -----------------------------------------------------------------------
    // Input catching
    // -----------------------------------------------------------------------
    tpc_pins_t pin_s;

    tpc_sync #(
        .W (4)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   (pins_i),
        .sync_o    (pin_s)   // RL18
    );

    logic sw_tune_q;
    logic sw_tune_d;
    logic tune_req;
    logic tune_req_q;
    logic tune_start;

    // A software tune behaves exactly like a one-cycle pulse on the synchronised pin.
    assign tune_req   = pin_s.tune_request | sw_tune_q;
    assign tune_start = tune_req & ~tune_req_q;

    // -----------------------------------------------------------------------
    // Delays
    // -----------------------------------------------------------------------
    logic tuning_latch_q;
    logic match_latch_q;
    logic rf_present;
    logic below_deb;
    logic reinsert_due;
    logic timeout_due;

    tpc_delay #(
        .W   (32),
        .LEN (RF_DELAY_CYC)
    ) u_rf_delay (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .run_i     (pin_s.rf_detect),
        .done_o    (rf_present)   // RL7 RL18
    );

    // Counting restarts whenever reflection rises, so brief dips never end
    // a tuning cycle; a tune pulse also holds the count at zero.
    tpc_delay #(
        .W   (32),
        .LEN (BELOW_DEB_CYC)
    ) u_below_deb (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .run_i     (pin_s.refl_below & ~tune_req), // RL9 RL14
        .done_o    (below_deb)
    );

    // The reinsertion count runs only while the pad is out and no match is
    // seen, so a match restarts it at once.
    tpc_delay #(
        .W   (32),
        .LEN (REINSERT_CYC)
    ) u_reinsert (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .run_i     (match_latch_q & ~below_deb), // RL3 RL11
        .done_o    (reinsert_due)
    );

    tpc_delay #(
        .W   (32),
        .LEN (TIMEOUT_CYC)
    ) u_timeout (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .run_i     (tuning_latch_q & ~tune_start),
        .done_o    (timeout_due)   // RL15
    );

    // -----------------------------------------------------------------------
    // Latches
    // -----------------------------------------------------------------------
    logic tuning_latch_d;
    logic match_latch_d;
    logic failure_latch_q;
    logic failure_latch_d;
    logic tuned_end;
    logic refl_fault;
    logic match_set;
    logic match_clr;

    assign tuned_end  = tuning_latch_q & rf_present & below_deb;
    assign refl_fault = ~pin_s.refl_below & ~tuning_latch_q;
    assign match_set  = rf_present & pin_s.refl_below;           // RL2
    assign match_clr  = tune_req                                 // RL1
                      | (tuning_latch_q & ~rf_present)           // RL8
                      | pin_s.ind_max                            // RL13
                      | reinsert_due                             // RL3
                      | refl_fault;                              // RL16

    always_comb begin
        tuning_latch_d = tuning_latch_q;
        if (tune_start) begin
            tuning_latch_d = 1'b1;
        end else if (timeout_due || tuned_end) begin
            tuning_latch_d = 1'b0;   // RL15 RL17
        end

        failure_latch_d = failure_latch_q;
        if (timeout_due || refl_fault) begin
            failure_latch_d = 1'b1;  // RL15 RL16
        end else if (tuning_latch_q || tuned_end) begin
            failure_latch_d = 1'b0;  // RL12
        end

        match_latch_d = match_latch_q;
        if (match_clr) begin
            match_latch_d = 1'b0;    // RL19
        end else if (match_set) begin
            match_latch_d = 1'b1;    // RL2
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tuning_latch_q  <= 1'b0;
            match_latch_q   <= 1'b0;
            failure_latch_q <= `TPC_RST_FAILURE;
            tune_req_q      <= 1'b0;
        end else begin
            tuning_latch_q  <= tuning_latch_d;
            match_latch_q   <= match_latch_d;
            failure_latch_q <= failure_latch_d;
            tune_req_q      <= tune_req;
        end
    end

    // -----------------------------------------------------------------------
    // Registers and interrupts
    // -----------------------------------------------------------------------
    tpc_irq_t    irq_stat_q;
    tpc_irq_t    irq_stat_d;
    tpc_irq_t    irq_mask_q;
    tpc_irq_t    irq_mask_d;
    tpc_irq_t    irq_evt;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        reinsert_q;

    always_comb begin
        irq_evt = '0;
        irq_evt[`TPC_IRQ_TUNED_BIT] = tuned_end;
        irq_evt[`TPC_IRQ_TMO_BIT]   = timeout_due & tuning_latch_q;
        irq_evt[`TPC_IRQ_REFL_BIT]  = refl_fault & ~failure_latch_q;
        irq_evt[`TPC_IRQ_REINS_BIT] = reinsert_due & ~reinsert_q;
    end

    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        sw_tune_d  = 1'b0;
        if (we_i && addr_i == `TPC_ADDR_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~wdata_i[3:0];
        end
        // A new event in the clearing cycle survives the clear.
        irq_stat_d = irq_stat_d | irq_evt;
        if (we_i && addr_i == `TPC_ADDR_IRQ_MASK) begin
            irq_mask_d = wdata_i[3:0];
        end
        if (we_i && addr_i == `TPC_ADDR_CTRL) begin
            sw_tune_d = wdata_i[`TPC_CTRL_TUNE_BIT];
        end

        rdata_d = '0;
        if (re_i) begin
            case (addr_i)
                `TPC_ADDR_STATUS: begin
                    rdata_d[0] = tuning_latch_q;
                    rdata_d[1] = failure_latch_q;
                    rdata_d[2] = match_latch_q;
                    rdata_d[3] = rf_present;
                    rdata_d[4] = below_deb;
                    rdata_d[5] = pin_s.ind_max;
                end
                `TPC_ADDR_IRQ_STAT: rdata_d[3:0] = irq_stat_q;
                `TPC_ADDR_IRQ_MASK: rdata_d[3:0] = irq_mask_q;
                default:            rdata_d      = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= `TPC_RST_MASK;
            sw_tune_q  <= 1'b0;
            rdata_q    <= '0;
            reinsert_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            sw_tune_q  <= sw_tune_d;
            rdata_q    <= rdata_d;
            reinsert_q <= reinsert_due;
        end
    end

    // -----------------------------------------------------------------------
    // Output stage
    // -----------------------------------------------------------------------
    tpc_lamps_t lamps_d;
    tpc_lamps_t lamps_q;
    logic       pad_q;
    logic       rfp_q;
    logic       mf_q;
    logic       home_n_q;
    logic       irq_q;

    always_comb begin
        lamps_d.fault  = failure_latch_q;                    // RL4
        lamps_d.ready  = ~tuning_latch_q & ~failure_latch_q; // RL5
        lamps_d.tuning = tuning_latch_q;                     // RL6
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lamps_q  <= '0;
            pad_q    <= 1'b1;
            rfp_q    <= 1'b0;
            mf_q     <= 1'b0;
            home_n_q <= 1'b1;
            irq_q    <= 1'b0;
        end else begin
            lamps_q  <= lamps_d;
            pad_q    <= ~match_latch_q;         // RL1 RL13
            rfp_q    <= rf_present;
            mf_q     <= below_deb;
            home_n_q <= ~tune_req;              // RL10
            irq_q    <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign rdata_o                = rdata_q;
    assign irq_o                  = irq_q;
    assign lamps_o                = lamps_q;
    assign pad_energize_o         = pad_q;
    assign rf_present_o           = rfp_q;
    assign match_found_o          = mf_q;
    assign capacitor_home_req_n_o = home_n_q;
    assign inductor_home_req_n_o  = home_n_q;

endmodule // tpc_top

`default_nettype wire

/* hdl/tpc_cfg.svh */
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// ---------------------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------------------
`define TPC_CLK_HZ          64'd40000000
`define TPC_RF_DELAY_US     64'd2000
`define TPC_BELOW_DEB_US    64'd1000
`define TPC_REINSERT_US     64'd3000
`define TPC_TIMEOUT_S       64'd40
`define TPC_RF_DELAY_CYC    (`TPC_RF_DELAY_US * `TPC_CLK_HZ / 64'd1000000)
`define TPC_BELOW_DEB_CYC   (`TPC_BELOW_DEB_US * `TPC_CLK_HZ / 64'd1000000)
`define TPC_REINSERT_CYC    (`TPC_REINSERT_US * `TPC_CLK_HZ / 64'd1000000)
`define TPC_TIMEOUT_CYC     (`TPC_TIMEOUT_S * `TPC_CLK_HZ)

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define TPC_ADDR_STATUS     8'h00
`define TPC_ADDR_IRQ_STAT   8'h04
`define TPC_ADDR_IRQ_MASK   8'h08
`define TPC_ADDR_CTRL       8'h0c

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define TPC_CTRL_TUNE_BIT   0
`define TPC_IRQ_TUNED_BIT   0
`define TPC_IRQ_TMO_BIT     1
`define TPC_IRQ_REFL_BIT    2
`define TPC_IRQ_REINS_BIT   3
`define TPC_IRQ_W           4

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define TPC_RST_MASK        4'h0
`define TPC_RST_FAILURE     1'b1

`endif

/* hdl/tpc_pkg.sv */
package tpc_pkg;

    typedef struct packed {
        logic tune_request;
        logic rf_detect;
        logic refl_below;
        logic ind_max;
    } tpc_pins_t;

    typedef struct packed {
        logic fault;
        logic ready;
        logic tuning;
    } tpc_lamps_t;

    typedef logic [3:0] tpc_irq_t;

endpackage

/* hdl/tpc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage input catcher; a change is taken once stages two and three agree.
module tpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,   // System clock.
    input  wire logic         reset_n_i,   // Async reset, active low.
    input  wire logic [W-1:0] async_i,     // Raw pin levels.
    output logic      [W-1:0] sync_o       // Clean levels.
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;
    logic [W-1:0] out_q;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= async_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_o = out_q;

endmodule // tpc_sync

`default_nettype wire

/* hdl/tpc_delay.sv */
`timescale 1ns/1ps
`default_nettype none

// Qualifying delay: the output rises once run_i has held for LEN cycles and
// drops in the same cycle run_i drops, so a release is never delayed.
module tpc_delay #(
    parameter int          W   = 32,
    parameter logic [W-1:0] LEN = '1
) (
    input  wire logic clk_sys_i,   // System clock.
    input  wire logic reset_n_i,   // Async reset, active low.
    input  wire logic run_i,       // Condition being qualified.
    output logic      done_o       // Condition held LEN cycles.
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        if (!run_i) begin
            cnt_d = '0;
        end else if (cnt_q == LEN) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = run_i && (cnt_q == LEN);

endmodule // tpc_delay

`default_nettype wire

/* sim/tpc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Port checker for the pad and lamp controller
// ---------------------------------------------------------------------
module tpc_chk #(
    parameter logic [31:0] RF_DELAY_CYC  = 32'd8,
    parameter logic [31:0] BELOW_DEB_CYC = 32'd8,
    parameter logic [31:0] REINSERT_CYC  = 32'd16
) (
    input wire logic                clk_sys_i,              // Clock.
    input wire logic                reset_n_i,              // Reset, low.
    input wire tpc_pkg::tpc_pins_t  pins_i,                 // Raw pins.
    input wire tpc_pkg::tpc_lamps_t lamps_o,                // Lamps.
    input wire logic                pad_energize_o,         // Pad in.
    input wire logic                rf_present_o,           // RF flag.
    input wire logic                match_found_o,          // Debounced.
    input wire logic                capacitor_home_req_n_o, // Home, low.
    input wire logic                inductor_home_req_n_o   // Home, low.
);
    import tpc_pkg::*;

    logic [31:0] rf_q, rf_d, bl_q, bl_d, rn_q, rn_d;

    // Run lengths are taken on the raw pins, so the input catcher's latency
    // adds margin to the delay checks and hides a count short by no more than it.
    always_comb begin
        rf_d = pins_i.rf_detect ? rf_q + 32'd1 : 32'd0;
        bl_d = pins_i.refl_below ? bl_q + 32'd1 : 32'd0;
        rn_d = (pad_energize_o || match_found_o) ? 32'd0 : rn_q + 32'd1;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rf_q <= 32'd0;
            bl_q <= 32'd0;
            rn_q <= 32'd0;
        end else begin
            rf_q <= rf_d;
            bl_q <= bl_d;
            rn_q <= rn_d;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_req_held;
        pins_i.tune_request [*8];
    endsequence

    sequence s_tune_dark;
        (lamps_o.tuning && !rf_present_o) [*3];
    endsequence

    a_home_low: assert property (
        s_req_held |-> !capacitor_home_req_n_o && !inductor_home_req_n_o)
        else $error("home lines not low during tune request");
    a_deb_held: assert property (
        s_req_held |-> !match_found_o)
        else $error("match found during tune request");
    a_pad_on_req: assert property (
        !capacitor_home_req_n_o |=> pad_energize_o)
        else $error("pad not inserted on tune request");
    a_pad_no_rf: assert property (
        s_tune_dark |-> pad_energize_o)
        else $error("pad dropped while tuning without RF");
    a_ind_max_pad: assert property (
        pins_i.ind_max [*8] |-> pad_energize_o)
        else $error("pad dropped with inductor at maximum");
    a_rf_delay: assert property (
        $rose(rf_present_o) |-> rf_q >= RF_DELAY_CYC)
        else $error("RF flag rose too early");
    a_deb_slow: assert property (
        $rose(match_found_o) |-> bl_q >= BELOW_DEB_CYC)
        else $error("match found rose too early");
    a_deb_fast: assert property (
        !pins_i.refl_below [*8] |-> !match_found_o)
        else $error("match found held with high reflection");
    a_match_rf: assert property (
        $fell(pad_energize_o) |-> $past(rf_present_o))
        else $error("pad dropped without RF present");
    a_reinsert_bound: assert property (
        rn_q <= REINSERT_CYC + 32'd4)
        else $error("pad not reinserted in time");
    a_fault_clear: assert property (
        $rose(lamps_o.tuning) |-> ##[0:1] !lamps_o.fault)
        else $error("fault lamp stayed on when tuning began");
    a_ready_lamp: assert property (
        lamps_o.ready |-> !lamps_o.tuning && !lamps_o.fault)
        else $error("ready lamp on while tuning or faulted");
endmodule // tpc_chk

bind tpc_top tpc_chk #(
    .RF_DELAY_CYC(RF_DELAY_CYC),
    .BELOW_DEB_CYC(BELOW_DEB_CYC),
    .REINSERT_CYC(REINSERT_CYC)
) u_chk (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pins_i(pins_i),
    .lamps_o(lamps_o),
    .pad_energize_o(pad_energize_o),
    .rf_present_o(rf_present_o),
    .match_found_o(match_found_o),
    .capacitor_home_req_n_o(capacitor_home_req_n_o),
    .inductor_home_req_n_o(inductor_home_req_n_o)
);

`default_nettype wire

/* sim/tpc_far.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Transmitter and antenna seen from the coupler input
// ---------------------------------------------------------------------
module tpc_far (
    input  wire logic       clk_sys_i, // Clock.
    input  wire logic       reset_n_i, // Reset, low.
    input  wire logic       key_i,     // Transmitter keyed.
    input  wire logic       bad_i,     // Antenna mismatched.
    input  wire logic [3:0] lag_i,     // Cycles for the match to settle.
    output logic            rf_o,      // RF at the coupler input.
    output logic            below_o    // Reflection below threshold.
);
    logic [3:0] age_q;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            age_q <= 4'h0;
        end else if (!key_i) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end

    // Unkeyed, the reflection amplifier is disabled and reports nothing;
    // keyed, reflection stays high until the match has settled.
    assign rf_o    = key_i;
    assign below_o = !key_i || (!bad_i && age_q >= lag_i);
endmodule // tpc_far

`default_nettype wire

/* sim/tpc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tpc_top_tb;
    import tpc_pkg::*;

    // -----------------------------------------------------------------
    // Shortened counts
    // -----------------------------------------------------------------
    localparam logic [31:0] TMO  = 32'd200;
    localparam int          CEIL = 5000;

    logic        clk_sys_i, reset_n_i, we_i, re_i, irq;
    logic        req, ind, key, bad, rf, below;
    logic        pad, rfp, mf, cap_n, ind_n;
    logic [3:0]  lag;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    logic [15:0] lfsr;
    tpc_pins_t   pins;
    tpc_lamps_t  lamps;
    int          errors, n_compared;
    int          cyc = 0;

    assign pins = '{tune_request: req, rf_detect: rf,
                    refl_below: below, ind_max: ind};

    tpc_top #(
        .RF_DELAY_CYC(32'd8), .BELOW_DEB_CYC(32'd8),
        .REINSERT_CYC(32'd16), .TIMEOUT_CYC(TMO)
    ) uut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .pins_i(pins),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .irq_o(irq), .lamps_o(lamps),
        .pad_energize_o(pad), .rf_present_o(rfp), .match_found_o(mf),
        .capacitor_home_req_n_o(cap_n), .inductor_home_req_n_o(ind_n)
    );

    tpc_far far (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .key_i(key),
        .bad_i(bad), .lag_i(lag), .rf_o(rf), .below_o(below)
    );

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        tick(1);
        we_i    <= 1'b0;
        tick(1);
    endtask

    // Read data stand only in the cycle after the strobe, so they are
    // taken mid-cycle, away from the edge that launches and drops them.
    task automatic rd(input logic [7:0] a);
        addr_i <= a;
        re_i   <= 1'b1;
        tick(1);
        re_i   <= 1'b0;
        @(negedge clk_sys_i);
        rv = rdata_o;
        tick(1);
    endtask

    task automatic finish_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            errors++;
            finish_test();
        end
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {reset_n_i, we_i, re_i, req, ind, key, bad} = '0;
        addr_i = '0;
        wdata_i = '0;
        lag = '0;
        lfsr = 16'hdacd;
        errors = 0;
        n_compared = 0;
        tick(20);
        reset_n_i <= 1'b1;
        tick(3);
        chk(lamps.fault, 1'b1);
        repeat (3) begin
            lfsr = nxt(lfsr);
            lag <= lfsr[3:0];
            req <= 1'b1;
            tick(8 + int'(lfsr[6:4]));
            chk(lamps.tuning, 1'b1);
            chk(lamps.fault, 1'b0);
            chk({cap_n, ind_n}, 2'b00);
            chk(pad, 1'b1);
            req <= 1'b0;
            tick(2);
            key <= 1'b1;
            for (int i = 0; i < 300 && lamps.ready !== 1'b1; i++) tick(1);
            chk(lamps.ready, 1'b1);
            chk(lamps.tuning, 1'b0);
            chk(pad, 1'b0);
            chk(rfp, 1'b1);
            chk(mf, 1'b1);
            key <= 1'b0;
            tick(20);
        end
        rd(8'h04);
        chk(rv & 32'h1, 32'h1);
        wr(8'h08, 32'h1);
        tick(2);
        chk(irq, 1'b1);
        wr(8'h04, 32'h1);
        tick(2);
        chk(irq, 1'b0);
        rd(8'h08);
        chk(rv, 32'h1);
        rd(8'h10);
        chk(rv, 32'h0);
        key <= 1'b1;
        tick(40);
        ind <= 1'b1;
        tick(10);
        chk(pad, 1'b1);
        ind <= 1'b0;
        tick(2);
        bad <= 1'b1;
        tick(10);
        chk(lamps.fault, 1'b1);
        chk(pad, 1'b1);
        bad <= 1'b0;
        key <= 1'b0;
        tick(10);
        wr(8'h0c, 32'h1);
        tick(4);
        chk(lamps.tuning, 1'b1);
        chk(lamps.fault, 1'b0);
        chk(pad, 1'b1);
        tick(int'(TMO) + 10);
        chk(lamps.tuning, 1'b0);
        chk(lamps.fault, 1'b1);
        rd(8'h00);
        chk(rv, 32'h12);
        rd(8'h04);
        chk(rv, 32'h6);
        wr(8'h08, 32'h2);
        tick(2);
        chk(irq, 1'b1);
        finish_test();
    end
endmodule // tpc_top_tb

`default_nettype wire
